// >>> can_mode_ctrl.v
// operating mode control and core control/status registers of a can controller
// How it works
// - config mode: no tx or rx, error counters cleared, interrupt flags untouched.
// - locked config register and the idle-stop, receive-capture and wake low-pass bits writable only in config mode.
// - config entry waits until an ongoing transmission ends.
// - disable mode: no tx/rx, wake flag may set, pins released, counters kept.
// - disable request while active waits for 11 recessive bits, then reports 001.
// - wake low-pass enable filters receive input while sleeping.
// - transmit after mode entry waits for 11 recessive bits first.
// - disable during that wait aborts the frame: aborted flag set, request cleared.
// - code 000 normal mode drives transmit and samples receive pin.
// - listen-only 011: no error flags, no ack, counters off, transmit pin released.
// - listen-all 111: ignore errors, accept all, keep partial frames.
// - loopback 010: internal tx routed to rx, both pins released.
// - request 100 is config; 101 and 110 are reserved.
// - current-mode field reports actual mode; both reset to config code.
// - idle-stop set halts the block in device idle.
// - abort-all cancels pending buffers; cleared by hardware when done.
// - receive-capture enable produces a capture event per error-free reception, or per any reception in listen-all.
// - window select 1 exposes filter window, 0 buffer window.
// - filter data bit count read-only, valid up to 10001.
// - matched filter index 0..15 of last received message.
// - interrupt source code names pending buffer or event, 1000000 none.
// - buffer count select and fifo start buffer fields.
// - current mode changes only after 11 recessive bits idle, except when leaving config or going from disable to config.
`timescale 1ns/10ps
`include "can_mode_map.vh"
module can_mode_ctrl #(
	parameter TX_BUFS = 8
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// register port
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	output reg [15:0] rdata,
	// protocol engine status
	input wire bit_tick,
	input wire tx_busy,
	input wire rx_frame_done,
	input wire rx_error,
	input wire [4:0] rx_filter_hit,
	input wire [4:0] filter_bit_count,
	input wire [6:0] pending_source,
	input wire [TX_BUFS-1:0] tx_request_set,
	input wire [TX_BUFS-1:0] tx_start_ok,
	input wire engine_tx,
	// device power state
	input wire device_idle,
	input wire sleeping,
	// bus pins
	input wire bus_receive_pin,
	output reg bus_transmit_pin,
	output reg bus_transmit_oe,
	output reg pins_released_rx,
	// to protocol engine
	output reg engine_rx,
	output reg tx_allowed,
	output reg rx_allowed,
	output reg ack_enable,
	output reg err_count_clear,
	output reg err_count_enable,
	output reg ignore_errors,
	output reg running,
	output reg rx_capture_event,
	output reg wake_flag,
	output reg [TX_BUFS-1:0] tx_request_flag,
	output reg [TX_BUFS-1:0] tx_aborted_flag,
	output reg [TX_BUFS-1:0] tx_go,
	output reg map_window_select,
	output reg [2:0] buffer_count_select,
	output reg [4:0] fifo_start_buffer,
	output reg [15:0] locked_cfg
);
	reg rx_s1, rx_s2;
	reg [2:0] lp_cnt;
	reg rx_f, rx_prev;
	reg [2:0] mode_request;
	reg [2:0] mode_current;
	reg idle_stop, abort_all_tx, rx_capture_enable, wake_lowpass_enable;
	reg [3:0] idle_cnt;
	reg bus_idle, tx_wait;
	reg [4:0] matched_filter_index;
	wire cfg = (mode_current == `MODE_CONFIG);
	wire halted = idle_stop & device_idle;
	wire rx_eff = (mode_current == `MODE_LOOPBACK) ? engine_tx : rx_f;

	function can_tx;
		input [2:0] m;
		begin
			can_tx = (m == `MODE_NORMAL) || (m == `MODE_LISTEN_ALL);
		end
	endfunction

	function reserved_mode;
		input [2:0] m;
		begin
			reserved_mode = (m == `MODE_RSVD5) || (m == `MODE_RSVD6);
		end
	endfunction

	// receive pin sync and optional wake low-pass
	always @(posedge clk) begin
		if (rst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			lp_cnt <= 3'h0;
			rx_f <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_s1 <= bus_receive_pin;
			rx_s2 <= rx_s1;
			rx_prev <= rx_f;
			// short glitches are rejected only while asleep, trading wake latency for noise immunity
			if (wake_lowpass_enable && sleeping) begin
				if (rx_s2 == rx_f)
					lp_cnt <= 3'h0;
				else if (lp_cnt == `LP_TAPS) begin
					rx_f <= rx_s2;
					lp_cnt <= 3'h0;
				end else
					lp_cnt <= lp_cnt + 3'h1;
			end else begin
				rx_f <= rx_s2;
				lp_cnt <= 3'h0;
			end
		end
	end

	// recessive bit counter for bus idle detection
	always @(posedge clk) begin
		if (rst) begin
			idle_cnt <= 4'h0;
			bus_idle <= 1'b0;
		end else if (!rx_eff) begin
			idle_cnt <= 4'h0;
			bus_idle <= 1'b0;
		end else if (bit_tick) begin
			if (idle_cnt == `IDLE_BITS - 4'h1)
				bus_idle <= 1'b1;
			else
				idle_cnt <= idle_cnt + 4'h1;
		end
	end

	// register writes and mode transitions
	always @(posedge clk) begin
		if (rst) begin
			mode_request <= `MODE_CONFIG;
			mode_current <= `MODE_CONFIG;
			idle_stop <= 1'b0;
			abort_all_tx <= 1'b0;
			rx_capture_enable <= 1'b0;
			map_window_select <= 1'b0;
			wake_lowpass_enable <= 1'b0;
			buffer_count_select <= 3'h0;
			fifo_start_buffer <= 5'h0;
			locked_cfg <= 16'h0000;
			tx_wait <= 1'b0;
			tx_request_flag <= {TX_BUFS{1'b0}};
			tx_aborted_flag <= {TX_BUFS{1'b0}};
			wake_flag <= 1'b0;
			matched_filter_index <= 5'h0;
		end else begin
			if (wr && addr == `ADDR_CONTROL_ONE) begin
				if (!reserved_mode(wdata[10:8]))
					mode_request <= wdata[10:8];
				map_window_select <= wdata[`BIT_WINDOW];
				if (cfg) begin
					idle_stop <= wdata[`BIT_IDLE_STOP];
					rx_capture_enable <= wdata[`BIT_RX_CAPTURE];
				end
			end
			if (wr && addr == `ADDR_FIFO_CONTROL) begin
				if (wdata[15:13] != `DMABS_RSVD)
					buffer_count_select <= wdata[15:13];
				fifo_start_buffer <= wdata[4:0];
			end
			if (wr && addr == `ADDR_LOCKED_CFG && cfg)
				locked_cfg <= wdata;
			if (wr && addr == `ADDR_SIDE_CONTROL && cfg)
				wake_lowpass_enable <= wdata[`BIT_WAKE_LP];
			if (rx_frame_done && rx_allowed && rx_filter_hit <= `FILHIT_MAX)
				matched_filter_index <= rx_filter_hit;
			// mode change when bus idle or leaving config; config entry also waits for tx end and skips the idle wait from disable
			if (mode_request != mode_current && !halted) begin
				if (mode_request == `MODE_CONFIG) begin
					if (!tx_busy && (bus_idle || mode_current == `MODE_DISABLE))
						mode_current <= mode_request;
				end else if (bus_idle || cfg) begin
					mode_current <= mode_request;
				end
				if (can_tx(mode_request) && (bus_idle || cfg))
					tx_wait <= 1'b1;
			end
			if (tx_wait && bus_idle)
				tx_wait <= 1'b0;
			// wake on bus activity while disabled
			if (mode_current == `MODE_DISABLE && rx_prev && !rx_f)
				wake_flag <= 1'b1;
			else if (wr && addr == `ADDR_SIDE_CONTROL && !wdata[1])
				wake_flag <= 1'b0;
			if (wr && addr == `ADDR_CONTROL_ONE && wdata[`BIT_ABORT_ALL])
				abort_all_tx <= 1'b1;
			else if (abort_all_tx && !tx_busy && tx_request_flag == {TX_BUFS{1'b0}})
				abort_all_tx <= 1'b0;
			// abort pending frames on disable during the wait or on abort-all
			if ((tx_wait && mode_request == `MODE_DISABLE) || (abort_all_tx && !tx_busy)) begin
				tx_aborted_flag <= tx_aborted_flag | tx_request_flag | tx_request_set;
				tx_request_flag <= {TX_BUFS{1'b0}};
			end else begin
				tx_request_flag <= (tx_request_flag | tx_request_set) & ~tx_go;
				tx_aborted_flag <= tx_aborted_flag & ~tx_request_set;
			end
		end
	end

	// mode decode to engine controls and pins
	always @(posedge clk) begin
		if (rst) begin
			tx_allowed <= 1'b0;
			rx_allowed <= 1'b0;
			ack_enable <= 1'b0;
			err_count_clear <= 1'b1;
			err_count_enable <= 1'b0;
			ignore_errors <= 1'b0;
			running <= 1'b0;
			bus_transmit_pin <= 1'b1;
			bus_transmit_oe <= 1'b0;
			pins_released_rx <= 1'b1;
			engine_rx <= 1'b1;
			rx_capture_event <= 1'b0;
			tx_go <= {TX_BUFS{1'b0}};
			rdata <= 16'h0000;
		end else begin
			running <= !halted && !cfg && mode_current != `MODE_DISABLE;
			tx_allowed <= !halted && can_tx(mode_current) && !tx_wait;
			rx_allowed <= !halted && !cfg && mode_current != `MODE_DISABLE;
			ack_enable <= mode_current == `MODE_NORMAL || mode_current == `MODE_LOOPBACK;
			err_count_clear <= cfg;
			err_count_enable <= mode_current == `MODE_NORMAL || mode_current == `MODE_LOOPBACK;
			ignore_errors <= mode_current == `MODE_LISTEN_ALL;
			bus_transmit_oe <= !halted && can_tx(mode_current);
			bus_transmit_pin <= engine_tx | ~can_tx(mode_current);
			pins_released_rx <= cfg || mode_current == `MODE_DISABLE || mode_current == `MODE_LOOPBACK;
			engine_rx <= rx_eff;
			rx_capture_event <= rx_capture_enable && rx_frame_done
				&& (!rx_error || mode_current == `MODE_LISTEN_ALL);
			tx_go <= (!halted && can_tx(mode_current) && !tx_wait && !abort_all_tx)
				? (tx_start_ok & tx_request_flag) : {TX_BUFS{1'b0}};
			if (!rd)
				rdata <= 16'h0000;
			else if (addr == `ADDR_CONTROL_ONE)
				rdata <= {2'b00, idle_stop, abort_all_tx, 1'b0, mode_request, mode_current, 1'b0,
					rx_capture_enable, 2'b00, map_window_select};
			else if (addr == `ADDR_CONTROL_TWO)
				rdata <= {11'h000, (filter_bit_count > `DNCNT_MAX) ? `DNCNT_MAX : filter_bit_count};
			else if (addr == `ADDR_INT_CODE)
				rdata <= {3'h0, matched_filter_index, 1'b0,
					(pending_source > `ICODE_FIFO) ? `ICODE_NONE : pending_source};
			else if (addr == `ADDR_FIFO_CONTROL)
				rdata <= {buffer_count_select, 8'h00, fifo_start_buffer};
			else if (addr == `ADDR_LOCKED_CFG)
				rdata <= locked_cfg;
			else if (addr == `ADDR_SIDE_CONTROL)
				rdata <= {14'h0000, wake_flag, wake_lowpass_enable};
			else
				rdata <= 16'h0000;
		end
	end
endmodule

// >>> can_mode_map.vh
// register offsets, field positions, codes and limits for the mode control block
`ifndef CAN_MODE_MAP_VH
`define CAN_MODE_MAP_VH
`define ADDR_CONTROL_ONE 4'h0
`define ADDR_CONTROL_TWO 4'h1
`define ADDR_INT_CODE 4'h2
`define ADDR_FIFO_CONTROL 4'h3
`define ADDR_LOCKED_CFG 4'h4
`define ADDR_SIDE_CONTROL 4'h5
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LOOPBACK 3'h2
`define MODE_LISTEN_ONLY 3'h3
`define MODE_CONFIG 3'h4
`define MODE_RSVD5 3'h5
`define MODE_RSVD6 3'h6
`define MODE_LISTEN_ALL 3'h7
`define BIT_IDLE_STOP 13
`define BIT_ABORT_ALL 12
`define BIT_RX_CAPTURE 3
`define BIT_WINDOW 0
`define BIT_WAKE_LP 0
`define IDLE_BITS 4'hb
`define ICODE_NONE 7'h40
`define ICODE_ERROR 7'h41
`define ICODE_WAKE 7'h42
`define ICODE_OVERFLOW 7'h43
`define ICODE_FIFO 7'h44
`define DNCNT_MAX 5'h11
`define FILHIT_MAX 5'h0f
`define DMABS_RSVD 3'h7
`define LP_TAPS 3'h3
`endif

// >>> can_mode_ctrl_assertions.sv
// concurrent checks on the ports of the can mode control block
`timescale 1ns/10ps
module can_mode_ctrl_assertions (
	input wire clk,
	input wire rst,
	input wire rd,
	input wire [15:0] rdata,
	input wire rx_frame_done,
	input wire [15:0] locked_cfg,
	input wire bus_transmit_oe,
	input wire pins_released_rx,
	input wire tx_allowed,
	input wire rx_allowed,
	input wire err_count_clear,
	input wire err_count_enable,
	input wire rx_capture_event
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0)
		else $error("read data not zero outside a read");
	cfg_quiet_a: assert property (err_count_clear |-> !tx_allowed && !rx_allowed)
		else $error("traffic allowed in config mode");
	cfg_counters_a: assert property (err_count_clear |-> !err_count_enable)
		else $error("error counters run while cleared");
	cfg_pin_a: assert property (err_count_clear |-> !bus_transmit_oe)
		else $error("transmit pin driven in config mode");
	drive_needs_tx_a: assert property (bus_transmit_oe |-> rx_allowed)
		else $error("pin driven in a mode that is not on line");
	released_pins_a: assert property (pins_released_rx |-> !bus_transmit_oe)
		else $error("transmit pin driven while pins released");
	capture_cause_a: assert property (rx_capture_event |-> $past(rx_frame_done))
		else $error("capture event without a reception");
	lock_hold_a: assert property ($changed(locked_cfg) |-> $past(err_count_clear))
		else $error("locked register changed while on line");
endmodule
bind can_mode_ctrl can_mode_ctrl_assertions chk_i (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
	.rx_frame_done(rx_frame_done), .locked_cfg(locked_cfg), .bus_transmit_oe(bus_transmit_oe),
	.pins_released_rx(pins_released_rx), .tx_allowed(tx_allowed), .rx_allowed(rx_allowed),
	.err_count_clear(err_count_clear), .err_count_enable(err_count_enable), .rx_capture_event(rx_capture_event));

// >>> can_bus_partner.sv
// other nodes on the shared bus: bit timing and wired-and bus level
`timescale 1ns/10ps
module can_bus_partner (
	input wire clk,
	input wire rst,
	input wire dominant,
	input wire tx_pin,
	input wire tx_oe,
	output reg bit_tick,
	output wire bus_level
);
	reg [1:0] div;
	// a dominant bit from anyone wins; a released pin leaves the bus recessive
	assign bus_level = !(dominant || (tx_oe && !tx_pin));
	always @(posedge clk) begin
		if (rst) begin
			div <= 2'h0;
			bit_tick <= 1'b0;
		end else begin
			div <= div + 2'h1;
			bit_tick <= (div == 2'h3);
		end
	end
endmodule

// >>> can_mode_ctrl_tb.sv
// self-checking bench for the can mode control block
`timescale 1ns/10ps
module can_mode_ctrl_tb;
	reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rx_frame_done = 1'b0, dom = 1'b0, engine_tx = 1'b1;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0;
	reg [7:0] tx_request_set = 8'h0;
	reg [4:0] rx_filter_hit = 5'h0, filter_bit_count = 5'h11;
	reg [6:0] pending_source = 7'h40;
	reg [2:0] m;
	wire [15:0] rdata;
	wire bit_tick, bus_receive_pin, bus_transmit_pin, bus_transmit_oe, engine_rx, tx_allowed;
	wire err_count_clear, rx_capture_event;
	wire [7:0] tx_request_flag, tx_aborted_flag;
	wire [2:0] buffer_count_select;
	integer err_count = 0, checked = 0, i;
	localparam [11:0] MODES = 12'h9da;
	can_mode_ctrl dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .bit_tick, .tx_busy(1'b0), .rx_frame_done,
		.rx_error(1'b0), .rx_filter_hit, .filter_bit_count, .pending_source, .tx_request_set,
		.tx_start_ok(8'h00), .engine_tx, .device_idle(1'b0), .sleeping(1'b0), .bus_receive_pin,
		.bus_transmit_pin, .bus_transmit_oe, .pins_released_rx(), .engine_rx, .tx_allowed, .rx_allowed(),
		.ack_enable(), .err_count_clear, .err_count_enable(), .ignore_errors(), .running(), .rx_capture_event,
		.wake_flag(), .tx_request_flag, .tx_aborted_flag, .tx_go(), .map_window_select(),
		.buffer_count_select, .fifo_start_buffer(), .locked_cfg());
	can_bus_partner node (.clk, .rst, .dominant(dom), .tx_pin(bus_transmit_pin), .tx_oe(bus_transmit_oe),
		.bit_tick, .bus_level(bus_receive_pin));
	initial forever #20 clk = ~clk;
	task chk(input [63:0] n, input [15:0] e, input [15:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("mismatch %0s exp %h got %h", n, e, g);
			end
		end
	endtask
	task wreg(input [3:0] a, input [15:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rchk(input [63:0] n, input [3:0] a, input [15:0] e);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 chk(n, e, rdata);
		end
	endtask
	task report_and_stop;
		begin
			$display("checked %0d err_count %0d", checked, err_count);
			if (err_count == 0 && checked > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		#200000;
		err_count = err_count + 1;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rchk("ctrl1", 4'h0, 16'h0480);
		rchk("ctrl2", 4'h1, 16'h0011);
		chk("clr", 16'h1, err_count_clear);
		wreg(4'h4, 16'h1234);
		rchk("lock", 4'h4, 16'h1234);
		wreg(4'h3, 16'hc01f);
		wreg(4'h3, 16'he01f);
		rchk("fifo", 4'h3, 16'hc01f);
		chk("bufs", 16'h6, buffer_count_select);
		wreg(4'h0, 16'h0500);
		rchk("rsvd", 4'h0, 16'h0480);
		wreg(4'h0, 16'h0008);
		rchk("normal", 4'h0, 16'h0008);
		wreg(4'h4, 16'hffff);
		rchk("locked", 4'h4, 16'h1234);
		@(posedge clk);
		rx_filter_hit <= 5'h0f;
		pending_source <= 7'h0f;
		rx_frame_done <= 1'b1;
		@(posedge clk);
		rx_frame_done <= 1'b0;
		#1 chk("cap", 16'h1, rx_capture_event);
		rchk("vec", 4'h2, 16'h0f0f);
		@(posedge clk);
		tx_request_set <= 8'h03;
		@(posedge clk);
		tx_request_set <= 8'h00;
		wreg(4'h0, 16'h1008);
		repeat (4) @(posedge clk);
		chk("reqs", 16'h0, tx_request_flag);
		chk("aborted", 16'h3, tx_aborted_flag);
		rchk("abort", 4'h0, 16'h0008);
		// keep the bus busy so the idle count restarts at the request
		@(posedge clk);
		dom <= 1'b1;
		repeat (8) @(posedge clk);
		wreg(4'h0, 16'h0108);
		dom <= 1'b0;
		rchk("wait", 4'h0, 16'h0108);
		repeat (60) @(posedge clk);
		rchk("disable", 4'h0, 16'h0128);
		chk("dis_oe", 16'h0, bus_transmit_oe);
		// a short dominant burst while disabled must raise the wake flag
		@(posedge clk);
		dom <= 1'b1;
		repeat (6) @(posedge clk);
		dom <= 1'b0;
		rchk("wake", 4'h5, 16'h0002);
		engine_tx <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			m = MODES[i*3 +: 3];
			wreg(4'h0, {5'h0, m, 8'h08});
			repeat (60) @(posedge clk);
			rchk("mode", 4'h0, {5'h0, m, m, 5'h08});
			if (m != 3'h7) chk("oe", 16'h0, bus_transmit_oe);
			if (m == 3'h2) chk("loop", 16'h0, engine_rx);
			// a looped dominant level would keep the bus busy and block the next mode change
			@(posedge clk) engine_tx <= 1'b1;
		end
		chk("cfg_clr", 16'h1, err_count_clear);
		chk("cfg_tx", 16'h0, tx_allowed);
		report_and_stop;
	end
endmodule
